// *** dv/field_contact_model.sv ***
// tested selector contacts: contact k joins test output k to input k
// assumes the device pulls an open input low
module field_contact_model #(parameter int CH = 4) (
  input  wire logic [CH-1:0] test_i,    // device test outputs
  input  wire logic [CH-1:0] closed_i,  // contacts closed by hand
  input  wire logic [CH-1:0] short_i,   // contacts welded to supply
  output logic      [CH-1:0] sel_o      // levels at device inputs
);
  timeunit 1ns;
  timeprecision 100ps;
  // identity wiring keeps odd with odd, even with even; a weld ignores gaps
  assign sel_o = (test_i & closed_i) | short_i;
endmodule : field_contact_model

// *** dv/safety_input_monitor.sv ***
// port checker for the safety input evaluation block
// assumes binding onto safety_input_eval, one clock, reset_i synchronous
module safety_input_monitor #(
  parameter int UNTESTED_MODES  = 8,
  parameter int TESTED_MODES    = 4,
  parameter int TEST_PERIOD_CYC = 300
) (
  input wire logic                        clk_i,
  input wire logic                        reset_i,
  input wire logic [1:0]                  th3a_i,
  input wire logic [3:0]                  th3c_i,
  input wire logic [UNTESTED_MODES-1:0]   sel_u_i,
  input wire logic [TESTED_MODES-1:0]     test_o,
  input wire logic                        th3a_valid_o,
  input wire logic                        th3a_err_o,
  input wire logic                        th3c_valid_o,
  input wire logic                        th3c_err_o,
  input wire safety_input_pkg::mode_res_s mode_u_o,
  input wire safety_input_pkg::mode_res_s mode_t_o,
  input wire logic [TESTED_MODES-1:0]     stuck_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HI_LEN = TEST_PERIOD_CYC - safety_input_pkg::TEST_GAP_CYC;  // high part of one period
  logic [15:0] gap_cnt_ff;   // low cycles of the current gap
  logic [31:0] hi_cnt_ff;    // high cycles of the current period
  logic [15:0] nxt_gap_cnt;
  logic        seen_hi_ff;   // low time under reset is not a gap
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  assign nxt_gap_cnt = test_o[0] ? 16'h0000 : gap_cnt_ff + 16'h0001;
  always_ff @(posedge clk_i) begin
    gap_cnt_ff <= reset_i ? 16'h0000 : nxt_gap_cnt;
    hi_cnt_ff  <= (reset_i || !test_o[0]) ? 32'h0000_0000 : hi_cnt_ff + 32'h0000_0001;
    seen_hi_ff <= !reset_i && (seen_hi_ff || test_o[0]);
  end
  sequence u_one_s; ($stable(sel_u_i) && $onehot(sel_u_i)) [*4]; endsequence
  sequence u_many_s; ($stable(sel_u_i) && !$onehot0(sel_u_i)) [*4]; endsequence
  hand_rise_a: assert property ($rose(th3a_valid_o) |-> $past(th3a_i, 3) == 2'b11) else $error("iiia early");
  hand_lock_a: assert property (th3a_err_o && |th3a_i |=> th3a_err_o && !th3a_valid_o) else $error("lock lost");
  iiic_rise_a: assert property ($rose(th3c_valid_o) |-> $past(th3c_i, 3) == 4'b0101) else $error("iiic early");
  iiic_lock_a: assert property ($rose(th3c_err_o) |-> !th3c_valid_o && $past(th3c_i, 3) != 4'b0101)
    else $error("iiic lock");
  mode_pick_a: assert property (u_one_s |=> mode_u_o.valid && $past(sel_u_i) == (UNTESTED_MODES'(1) << mode_u_o.idx))
    else $error("wrong mode");
  mode_clash_a: assert property (u_many_s |=> mode_u_o.err && !mode_u_o.valid) else $error("no clash");
  gap_length_a: assert property ($rose(test_o[0]) && seen_hi_ff |-> gap_cnt_ff == 16'(safety_input_pkg::TEST_GAP_CYC))
    else $error("gap length");
  period_high_a: assert property ($fell(test_o[0]) && seen_hi_ff |-> hi_cnt_ff == 32'(HI_LEN))
    else $error("period length");
  stuck_err_a: assert property ($rose(|stuck_o) |=> mode_t_o.err && !mode_t_o.valid)
    else $error("weld ignored");
endmodule : safety_input_monitor

bind safety_input_eval safety_input_monitor #(.UNTESTED_MODES(UNTESTED_MODES), .TESTED_MODES(TESTED_MODES),
  .TEST_PERIOD_CYC(TEST_PERIOD_CYC)) safety_input_monitor_i (.clk_i(clk_i), .reset_i(reset_i),
  .th3a_i(th3a_i), .th3c_i(th3c_i), .sel_u_i(sel_u_i), .test_o(test_o), .th3a_valid_o(th3a_valid_o),
  .th3a_err_o(th3a_err_o), .th3c_valid_o(th3c_valid_o), .th3c_err_o(th3c_err_o), .mode_u_o(mode_u_o),
  .mode_t_o(mode_t_o), .stuck_o(stuck_o));

// *** dv/test_safety_input_eval.sv ***
// self-checking bench for the safety input evaluation block
// assumes package, design, checker and contact model compiled first
module test_safety_input_eval;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SYNC = 50, TPER = 300, LIMIT = 12000;  // short counts keep the run brief
  logic                        clk = 1'b0, reset = 1'b1;
  logic [1:0]                  th3a = 2'b00;
  logic [3:0]                  th3c = 4'b1010, closed = 4'h0, shorted = 4'h0;  // all released
  logic [7:0]                  sel_u = 8'h00;
  logic [3:0]                  sel_t, test, stuck;
  logic                        a_valid, a_err, c_valid, c_err;
  safety_input_pkg::mode_res_s mode_u, mode_t;
  int                          fails = 0, compares = 0, cycles = 0;
  always #4 clk = ~clk;  // 125 MHz
  safety_input_eval #(.UNTESTED_MODES(8), .TESTED_MODES(4), .SYNC_CYC(SYNC), .TEST_PERIOD_CYC(TPER))
    safety_input_eval_i (.clk_i(clk), .reset_i(reset), .th3a_i(th3a), .th3c_i(th3c), .sel_u_i(sel_u),
    .sel_t_i(sel_t), .test_o(test), .th3a_valid_o(a_valid), .th3a_err_o(a_err), .th3c_valid_o(c_valid),
    .th3c_err_o(c_err), .mode_u_o(mode_u), .mode_t_o(mode_t), .stuck_o(stuck));
  field_contact_model #(.CH(4)) field_contact_model_i (.test_i(test), .closed_i(closed), .short_i(shorted),
    .sel_o(sel_t));
  // inputs move 1 ns after the edge, never on it
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic hold(input logic [1:0] a, input logic [3:0] c, input int n);
    th3a = a;
    th3c = c;
    step(n);
  endtask : hold
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) fails++;
    if (got !== exp) $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
  endtask : chk
  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) fails++;
    if (cycles == LIMIT) report_and_stop();
  end
  // press, partial release, late button, late press inside the window, then the contact pairs
  task automatic t_two_hand();
    hold(2'b11, 4'b1010, 6);
    chk(8'(a_valid), 8'h01, "iiia press");
    hold(2'b01, 4'b1010, 6);
    hold(2'b11, 4'b1010, 6);
    chk(8'(a_valid), 8'h00, "iiia without release");
    hold(2'b00, 4'b1010, 6);
    hold(2'b10, 4'b1010, SYNC + 20);
    hold(2'b11, 4'b1010, 6);
    chk({6'h00, a_valid, a_err}, 8'h01, "iiia late");
    hold(2'b00, 4'b1010, 6);
    hold(2'b01, 4'b1010, SYNC - 10);
    hold(2'b11, 4'b0101, 6);
    chk({6'h00, a_valid, c_valid}, 8'h03, "inside window");
    hold(2'b00, 4'b1010, 6);
    hold(2'b00, 4'b0111, 6);
    chk(8'(c_valid), 8'h00, "iiic contradictory pair");
    hold(2'b00, 4'b1010, 6);
    hold(2'b00, 4'b1001, SYNC + 20);
    hold(2'b00, 4'b0101, 6);
    chk({6'h00, c_valid, c_err}, 8'h01, "iiic late");
    hold(2'b00, 4'b1010, 6);
    chk({6'h00, a_err, c_err}, 8'h00, "release unlocks");
  endtask : t_two_hand
  // every mode of both selectors, clashes, and a welded contact
  task automatic t_modes();
    for (int k = 0; k < 8; k++) begin
      sel_u = 8'h01 << k;
      step(5);
      chk(8'(mode_u), 8'h10 + 8'(k), "untested pick");
    end
    sel_u = 8'h81;
    step(5);
    chk({6'h00, mode_u.valid, mode_u.err}, 8'h01, "untested clash");
    for (int k = 0; k < 4; k++) begin
      closed = 4'h1 << k;
      step(2 * TPER + 20);
      chk(8'(mode_t), 8'h10 + 8'(k), "tested pick");
    end
    closed = 4'h5;
    step(2 * TPER + 20);
    chk({6'h00, mode_t.valid, mode_t.err}, 8'h01, "tested clash");
    shorted = 4'h4;
    step(2 * TPER + 20);
    chk({4'h0, stuck}, 8'h04, "welded contact");
    chk({6'h00, mode_t.valid, mode_t.err}, 8'h01, "weld error");
  endtask : t_modes
  initial begin
    step(2);
    reset = 1'b0;
    step(4);
    t_two_hand();
    t_modes();
    report_and_stop();
  end
endmodule : test_safety_input_eval

// *** inc/safety_input_pkg.sv ***
// shared constants and carrier types for the safety input evaluation block
// assumes a 125 MHz controller clock and field contacts sampled through pin synchronisers
package safety_input_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ         = 125000;                     // controller clock rate in kHz
  localparam int SYNC_WINDOW_MS  = 500;                        // two-hand simultaneity window
  localparam int SYNC_WINDOW_CYC = SYNC_WINDOW_MS * CLK_KHZ;   // longest time, exact at this rate
  localparam int TEST_PERIOD_US  = 1000;                       // test output repetition period
  localparam int TEST_PERIOD_CYC = (TEST_PERIOD_US * CLK_KHZ) / 1000;
  localparam int TEST_GAP_NS     = 1000;                       // low gap of each test pulse
  localparam int TEST_GAP_CYC    = (TEST_GAP_NS * (CLK_KHZ / 1000)) / 1000;
  localparam int SETTLE_CYC      = 4;                          // pin path latency after a gap
  localparam int CNT_W           = 32;                         // width of long timing counters

  // ----------------------------------------------------------------
  // mode selector limits
  // ----------------------------------------------------------------
  localparam int MODE_MIN        = 2;   // fewest selectable modes
  localparam int UNTESTED_MAX    = 8;   // most modes without test pulses
  localparam int TESTED_MAX      = 4;   // most modes with test pulses
  localparam int MODE_IDX_W      = 3;   // index width covering eight modes
  localparam int MODE_VEC_W      = 8;   // common width used by the decode functions

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  valid;   // exactly one selector contact closed; for the tested selector also no contact stuck
    logic                  err;     // several contacts closed, or for the tested selector a contact stuck
    logic [MODE_IDX_W-1:0] idx;     // selected mode, zero based
  } mode_res_s;

  localparam mode_res_s MODE_RES_RST = '{valid: 1'b0, err: 1'b0, idx: 3'h0};

endpackage : safety_input_pkg

// *** src/safety_input_eval.sv ***
// evaluation of two-hand controls and operating mode selectors
// assumes all contact inputs come straight from pins; test outputs drive tested selector contacts
// ----------------------------------------------------------------
module safety_input_eval #(
  parameter int UNTESTED_MODES  = safety_input_pkg::UNTESTED_MAX,     // modes of the untested selector
  parameter int TESTED_MODES    = safety_input_pkg::TESTED_MAX,       // modes of the tested selector
  parameter int SYNC_CYC        = safety_input_pkg::SYNC_WINDOW_CYC,  // two-hand window in cycles
  parameter int TEST_PERIOD_CYC = safety_input_pkg::TEST_PERIOD_CYC   // test pulse period in cycles
) (
  input  wire logic                          clk_i,          // controller clock
  input  wire logic                          reset_i,        // synchronous reset, active high
  input  wire logic [1:0]                    th3a_i,         // IIIA buttons, high when pressed
  input  wire logic [3:0]                    th3c_i,         // IIIC: [0] NO1 [1] NC1 [2] NO2 [3] NC2
  input  wire logic [UNTESTED_MODES-1:0]     sel_u_i,        // untested selector contacts
  input  wire logic [TESTED_MODES-1:0]       sel_t_i,        // tested selector contacts
  output logic [TESTED_MODES-1:0]            test_o,         // test outputs feeding sel_t_i
  output logic                               th3a_valid_o,   // IIIA command valid
  output logic                               th3a_err_o,     // IIIA window missed
  output logic                               th3c_valid_o,   // IIIC command valid
  output logic                               th3c_err_o,     // IIIC window missed
  output safety_input_pkg::mode_res_s        mode_u_o,       // untested selector result
  output safety_input_pkg::mode_res_s        mode_t_o,       // tested selector result
  output logic [TESTED_MODES-1:0]            stuck_o         // tested contact failed its gap check
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // number of closed contacts
  function automatic logic [3:0] count_ones(input logic [safety_input_pkg::MODE_VEC_W-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < safety_input_pkg::MODE_VEC_W; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction : count_ones

  // position of the highest closed contact, meaningful when exactly one is closed
  function automatic logic [safety_input_pkg::MODE_IDX_W-1:0] first_idx(
    input logic [safety_input_pkg::MODE_VEC_W-1:0] v);
    logic [safety_input_pkg::MODE_IDX_W-1:0] k;
    k = '0;
    for (int i = 0; i < safety_input_pkg::MODE_VEC_W; i++) begin
      if (v[i]) k = safety_input_pkg::MODE_IDX_W'(i);
    end
    return k;
  endfunction : first_idx

  // ----------------------------------------------------------------
  // pin synchronisers; stage one feeds stage two only
  // ----------------------------------------------------------------
  localparam int PIN_W = 6 + UNTESTED_MODES + TESTED_MODES;

  logic [PIN_W-1:0] pin_meta_ff;   // first stage
  logic [PIN_W-1:0] pin_sync_ff;   // second stage, the only one logic reads

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= {sel_t_i, sel_u_i, th3c_i, th3a_i};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  wire [1:0]                th3a_s  = pin_sync_ff[1:0];
  wire [3:0]                th3c_s  = pin_sync_ff[5:2];
  wire [UNTESTED_MODES-1:0] sel_u_s = pin_sync_ff[6 +: UNTESTED_MODES];
  wire [TESTED_MODES-1:0]   sel_t_s = pin_sync_ff[6+UNTESTED_MODES +: TESTED_MODES];

  // ----------------------------------------------------------------
  // two-hand controls
  // ----------------------------------------------------------------
  // IIIA: equivalent contacts, high is on and low is off
  wire [1:0] th3a_on  = th3a_s;
  wire [1:0] th3a_off = ~th3a_s;
  // IIIC: each button is an NO/NC pair; contradictory pairs are neither on nor off
  wire [1:0] th3c_on  = {th3c_s[2] & ~th3c_s[3], th3c_s[0] & ~th3c_s[1]};
  wire [1:0] th3c_off = {~th3c_s[2] & th3c_s[3], ~th3c_s[0] & th3c_s[1]};

  two_hand_eval #(.WINDOW_CYC(SYNC_CYC)) u_th3a (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .on_i    (th3a_on),
    .off_i   (th3a_off),
    .valid_o (th3a_valid_o),
    .err_o   (th3a_err_o)
  );

  two_hand_eval #(.WINDOW_CYC(SYNC_CYC)) u_th3c (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .on_i    (th3c_on),
    .off_i   (th3c_off),
    .valid_o (th3c_valid_o),
    .err_o   (th3c_err_o)
  );

  // ----------------------------------------------------------------
  // test pulse generator
  // ----------------------------------------------------------------
  localparam logic [safety_input_pkg::CNT_W-1:0] PER_LAST  =
    safety_input_pkg::CNT_W'(TEST_PERIOD_CYC - 1);
  localparam logic [safety_input_pkg::CNT_W-1:0] GAP_LEN   =
    safety_input_pkg::CNT_W'(safety_input_pkg::TEST_GAP_CYC);
  localparam logic [safety_input_pkg::CNT_W-1:0] GAP_CHECK =
    safety_input_pkg::CNT_W'(safety_input_pkg::TEST_GAP_CYC - 1);
  localparam logic [safety_input_pkg::CNT_W-1:0] HOLD_END  =
    safety_input_pkg::CNT_W'(safety_input_pkg::TEST_GAP_CYC + safety_input_pkg::SETTLE_CYC);

  logic [safety_input_pkg::CNT_W-1:0] per_cnt_ff;   // position inside the test period
  logic [TESTED_MODES-1:0]            test_ff;      // test output levels

  wire per_wrap  = (per_cnt_ff == PER_LAST);
  wire in_gap    = (per_cnt_ff < GAP_LEN);     // outputs pulled low
  wire gap_check = (per_cnt_ff == GAP_CHECK);  // contacts must read low by now
  wire hold_sel  = (per_cnt_ff < HOLD_END);    // gap still visible through the pin path

  // all outputs share one timing; contact k is fed by output k, so parity always matches
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      per_cnt_ff <= '0;
      test_ff    <= '0;
    end else begin
      per_cnt_ff <= per_wrap ? '0 : per_cnt_ff + 1'b1;
      test_ff    <= {TESTED_MODES{~in_gap}};
    end
  end

  assign test_o = test_ff;

  // ----------------------------------------------------------------
  // tested selector: gap check and level hold
  // ----------------------------------------------------------------
  logic [TESTED_MODES-1:0] stuck_ff;   // contact stayed high through a gap, sticky until reset
  logic [TESTED_MODES-1:0] sel_t_ff;   // tested levels with gaps masked out

  // a contact that is high while its feed is low is shorted to supply
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stuck_ff <= '0;
    end else if (gap_check) begin
      stuck_ff <= stuck_ff | sel_t_s;
    end
  end

  // the gap would look like an open contact, so the last clean level is held across it;
  // a change shorter than TEST_GAP_CYC + SETTLE_CYC cycles can therefore go unseen
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sel_t_ff <= '0;
    end else if (!hold_sel) begin
      sel_t_ff <= sel_t_s & ~stuck_ff;
    end
  end

  assign stuck_o = stuck_ff;

  // ----------------------------------------------------------------
  // selector decode
  // ----------------------------------------------------------------
  wire [safety_input_pkg::MODE_VEC_W-1:0] u_vec = safety_input_pkg::MODE_VEC_W'(sel_u_s);
  wire [safety_input_pkg::MODE_VEC_W-1:0] t_vec = safety_input_pkg::MODE_VEC_W'(sel_t_ff);
  wire [3:0] u_cnt  = count_ones(u_vec);
  wire [3:0] t_cnt  = count_ones(t_vec);

  safety_input_pkg::mode_res_s nxt_mode_u;   // untested result before the register
  safety_input_pkg::mode_res_s nxt_mode_t;   // tested result before the register

  assign nxt_mode_u.valid = (u_cnt == 4'h1);
  assign nxt_mode_u.err   = (u_cnt > 4'h1);
  assign nxt_mode_u.idx   = nxt_mode_u.valid ? first_idx(u_vec) : '0;
  assign nxt_mode_t.valid = (t_cnt == 4'h1) && (stuck_ff == '0);
  assign nxt_mode_t.err   = (t_cnt > 4'h1) || (stuck_ff != '0);
  assign nxt_mode_t.idx   = nxt_mode_t.valid ? first_idx(t_vec) : '0;

  safety_input_pkg::mode_res_s mode_u_ff;   // registered untested result
  safety_input_pkg::mode_res_s mode_t_ff;   // registered tested result

  // results leave from flip-flops; no mode is reported until reset is over
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_u_ff <= safety_input_pkg::MODE_RES_RST;
      mode_t_ff <= safety_input_pkg::MODE_RES_RST;
    end else begin
      mode_u_ff <= nxt_mode_u;
      mode_t_ff <= nxt_mode_t;
    end
  end

  assign mode_u_o = mode_u_ff;
  assign mode_t_o = mode_t_ff;

endmodule : safety_input_eval

// *** src/two_hand_eval.sv ***
// simultaneity and release check for one two-hand control station
// assumes on/off qualifiers per button, already synchronised to clk_i
module two_hand_eval #(
  parameter int WINDOW_CYC = safety_input_pkg::SYNC_WINDOW_CYC  // simultaneity window in cycles
) (
  input  wire logic       clk_i,      // controller clock
  input  wire logic       reset_i,    // synchronous reset, active high
  input  wire logic [1:0] on_i,       // button reads in its on state
  input  wire logic [1:0] off_i,      // button reads in its off state
  output logic            valid_o,    // two-hand command valid
  output logic            err_o       // window missed, waiting for both released
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {WAIT_OFF, ARMED, TIMING, ACTIVE, LOCKED} th_state_e;

  th_state_e                         state_ff;      // current state
  th_state_e                         nxt_state;     // next state
  logic [safety_input_pkg::CNT_W-1:0] cnt_ff;       // cycles since first button moved
  logic [safety_input_pkg::CNT_W-1:0] nxt_cnt;      // next counter value
  logic                               valid_ff;     // registered valid
  logic                               err_ff;       // registered window error

  wire both_on  = &on_i;    // both buttons pressed
  wire both_off = &off_i;   // both buttons released
  wire win_end  = (cnt_ff >= safety_input_pkg::CNT_W'(WINDOW_CYC - 1));  // last cycle of the window

  // ----------------------------------------------------------------
  // next state; a command is only possible from a full release
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = '0;
    case (state_ff)
      WAIT_OFF: begin
        if (both_off) nxt_state = ARMED;
      end
      ARMED: begin
        if (both_on) nxt_state = ACTIVE;
        else if (!both_off) nxt_state = TIMING;       // first button moved, window opens
      end
      TIMING: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (both_on) nxt_state = ACTIVE;
        else if (both_off) nxt_state = ARMED;         // let go again, re-armed
        else if (win_end) nxt_state = LOCKED;
      end
      ACTIVE: begin
        if (!both_on) nxt_state = WAIT_OFF;
      end
      LOCKED: begin
        if (both_off) nxt_state = ARMED;
      end
      default: nxt_state = WAIT_OFF;
    endcase
  end

  // ----------------------------------------------------------------
  // registers; reset starts by demanding a full release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= WAIT_OFF;
      cnt_ff   <= '0;
      valid_ff <= 1'b0;
      err_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      valid_ff <= (nxt_state == ACTIVE);
      err_ff   <= (nxt_state == LOCKED);
    end
  end

  assign valid_o = valid_ff;
  assign err_o   = err_ff;

endmodule : two_hand_eval
